// file: core/drc_run_ctrl.v
// Debug run control: reset and interrupt masking, halt and standby stepping.
// Assumes event inputs are synchronous pulses or levels on i_clk, except
// the pin reset, which is synchronised here.
//
// Operation
// - Stepping masks user-system resets.
// - Masked user resets pend until mask lifts.
// - Debugger reset always resets and breaks in the same cycle.
// - Break/step mask and pend three interrupts.
// - Free run passes interrupts unmasked except during a reset.
// - Entering break releases halt.
// - Stepped halt breaks at next instruction.
// - Stepped deep standby breaks at reset address.
`include "drc_map.vh"
module drc_run_ctrl (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_pin_rst_n,
  input wire i_sw_rst,
  input wire i_dbg_rst,
  input wire i_dbg_break,
  input wire i_dbg_step,
  input wire i_dbg_go,
  input wire i_instr_done,
  input wire i_halt_instr,
  input wire i_deep_standby_instr,
  input wire i_maskable_user_interrupt,
  input wire i_fast_exception_interrupt,
  input wire i_float_exception_interrupt,
  input wire i_irq_ack,
  output reg o_cpu_rst,
  output reg o_in_break,
  output reg o_halted,
  output reg o_deep_standby_state,
  output reg o_break_at_reset_vec,
  output reg [`DRC_IRQ_W-1:0] o_irq_req
);
  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  reg pin_s1_r;
  reg pin_s2_r;
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
    end else begin
      pin_s1_r <= ~i_pin_rst_n;
      pin_s2_r <= pin_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // Run state
  // ----------------------------------------------------------------
  reg [1:0] st_r;
  reg [1:0] st_nxt;
  reg [3:0] rcnt_r;
  reg dbg_rst_r;
  // Run-state decoders shared by the masks and the outputs
  function drc_is_run;
    input [1:0] state;
    begin
      drc_is_run = (state == `DRC_ST_RUN);
    end
  endfunction
  function drc_is_brk;
    input [1:0] state;
    begin
      drc_is_brk = (state == `DRC_ST_BRK);
    end
  endfunction
  wire masked = !drc_is_run(st_r);
  wire user_rst_evt = pin_s2_r | i_sw_rst;
  wire rst_req;
  wire [`DRC_IRQ_W-1:0] irq_evt = {i_float_exception_interrupt,
    i_fast_exception_interrupt, i_maskable_user_interrupt};
  wire [`DRC_IRQ_W-1:0] irq_live;
  wire step_end = (st_r == `DRC_ST_STEP) && i_instr_done;
  // Reset in progress also counts as masking for the interrupts so their pended events wait for it
  wire rst_busy = (rcnt_r != 4'h0);
  // Debugger reset ignores the mask; user reset only when unmasked
  wire rst_start = i_dbg_rst || (rst_req && !rst_busy);
  // Next state is break: entered by command, step end or debugger reset, or held
  wire brk_entry = drc_is_brk(st_nxt);

  // User reset held while masked (in break or step)
  drc_pend u_rst_pend (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_evt(user_rst_evt),
    .i_mask(masked),
    .i_flush(i_dbg_rst),
    .i_taken(rst_busy),
    .o_req(rst_req)
  );

  genvar g;
  generate
    for (g = 0; g < `DRC_IRQ_W; g = g + 1) begin : g_irq
      drc_pend u_irq_pend (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_evt(irq_evt[g]),
        .i_mask(masked | rst_busy),
        .i_flush(rst_req | i_dbg_rst),
        .i_taken(i_irq_ack),
        .o_req(irq_live[g])
      );
    end
  endgenerate

  always @* begin
    st_nxt = st_r;
    case (st_r)
      `DRC_ST_RUN: begin
        if (i_dbg_break) begin
          st_nxt = `DRC_ST_BRK;
        end
      end
      `DRC_ST_BRK: begin
        if (i_dbg_step) begin
          st_nxt = `DRC_ST_STEP;
        end else if (i_dbg_go) begin
          st_nxt = `DRC_ST_RUN;
        end
      end
      `DRC_ST_STEP: begin
        if (step_end || i_dbg_break) begin
          st_nxt = `DRC_ST_BRK;
        end
      end
      default: begin
        st_nxt = `DRC_ST_BRK;
      end
    endcase
    // Held only while the pulse counts, so a go after it is not lost
    if (i_dbg_rst || (dbg_rst_r && rst_busy)) begin
      st_nxt = `DRC_ST_BRK;
    end
  end

  // ----------------------------------------------------------------
  // Reset sequencer
  // ----------------------------------------------------------------
  // A user reset is not relaunched while one counts, so a held request
  // level gives back-to-back pulses rather than one endless pulse
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rcnt_r <= 4'h0;
      dbg_rst_r <= 1'b0;
      o_cpu_rst <= 1'b0;
    end else begin
      if (rst_start) begin
        rcnt_r <= `DRC_RST_CYC;
      end else if (rst_busy) begin
        rcnt_r <= rcnt_r - 4'h1;
      end
      if (i_dbg_rst) begin
        dbg_rst_r <= 1'b1;
      end else if (!rst_busy) begin
        dbg_rst_r <= 1'b0;
      end
      o_cpu_rst <= rst_start || (rcnt_r > 4'h1);
    end
  end

  // ----------------------------------------------------------------
  // Run state and low-power outputs
  // ----------------------------------------------------------------
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= `DRC_ST_RUN;
      o_in_break <= 1'b0;
      o_halted <= 1'b0;
      o_deep_standby_state <= 1'b0;
      o_break_at_reset_vec <= 1'b0;
    end else begin
      st_r <= st_nxt;
      o_in_break <= drc_is_brk(st_nxt);
      // Halt: entered only in free run, left on any break
      if (brk_entry) begin
        o_halted <= 1'b0;
      end else if (i_halt_instr && drc_is_run(st_r)) begin
        o_halted <= 1'b1;
      end else if (|irq_live) begin
        o_halted <= 1'b0;
      end
      // Deep standby replaced by a reset-address break when stepping
      if (brk_entry) begin
        o_deep_standby_state <= 1'b0;
      end else if (i_deep_standby_instr && drc_is_run(st_r)) begin
        o_deep_standby_state <= 1'b1;
      end
      if (step_end && i_deep_standby_instr) begin
        o_break_at_reset_vec <= 1'b1;
      end else if (!drc_is_brk(st_nxt)) begin
        o_break_at_reset_vec <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt requests
  // ----------------------------------------------------------------
  // Requests are dropped for the whole reset so that no handler starts
  // on a core that is still held in reset
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq_req <= {`DRC_IRQ_W{1'b0}};
    end else begin
      o_irq_req <= (rst_req || rst_busy || i_dbg_rst) ?
        {`DRC_IRQ_W{1'b0}} : irq_live;
    end
  end
endmodule // drc_run_ctrl

// file: core/drc_map.vh
// Constants for the debug run-control block.
// Assumes inclusion by bare name from core and checker files.
`ifndef DRC_MAP_VH
`define DRC_MAP_VH
// Run states
`define DRC_ST_RUN 2'h0
`define DRC_ST_BRK 2'h1
`define DRC_ST_STEP 2'h2
// Pending interrupt vector bit positions
`define DRC_IRQ_EI 0
`define DRC_IRQ_FE 1
`define DRC_IRQ_FP 2
`define DRC_IRQ_W 3
// Reset pulse length in cycles
`define DRC_RST_CYC 4'h4
`endif

// file: core/drc_pend.v
// Holds one pending event while it is masked and releases it afterwards.
// Assumes i_evt comes from logic on the same clock.
module drc_pend (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_evt,
  input wire i_mask,
  input wire i_flush,
  input wire i_taken,
  output wire o_req
);
  reg pend_r;
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pend_r <= 1'b0;
    end else if (i_evt && i_mask) begin
      // Set wins over any clear in the same cycle
      pend_r <= 1'b1;
    end else if (i_flush || (i_taken && !i_mask)) begin
      pend_r <= 1'b0;
    end
  end
  assign o_req = !i_mask && (pend_r || i_evt);
endmodule // drc_pend

// file: testbench/drc_chk_sva.sv
// Assertion checker for the run-control outputs.
// Assumes it is bound onto drc_run_ctrl.
`include "drc_map.vh"
module drc_chk (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_dbg_rst,
  input wire i_dbg_go,
  input wire o_cpu_rst,
  input wire o_in_break,
  input wire o_halted,
  input wire o_deep_standby_state,
  input wire o_break_at_reset_vec,
  input wire [`DRC_IRQ_W-1:0] o_irq_req
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_rst4; o_cpu_rst [*4] ##1 !o_cpu_rst; endsequence
  property p_pulse; $rose(o_cpu_rst) |-> s_rst4; endproperty
  a_pulse: assert property (p_pulse) else $error("reset length");
  property p_drst; i_dbg_rst |=> o_cpu_rst && o_in_break; endproperty
  a_drst: assert property (p_drst) else $error("debug reset");
  property p_wake; $rose(o_in_break) |-> !o_halted; endproperty
  a_wake: assert property (p_wake) else $error("halt kept");
  property p_mask; o_in_break && $past(o_in_break) |-> !o_irq_req; endproperty
  a_mask: assert property (p_mask) else $error("irq in break");
  property p_rmsk; $rose(o_cpu_rst) && o_in_break |-> $past(i_dbg_rst);
  endproperty
  a_rmsk: assert property (p_rmsk) else $error("reset unmasked");
  property p_ds;
    $rose(o_break_at_reset_vec) |-> o_in_break && !o_deep_standby_state;
  endproperty
  a_ds: assert property (p_ds) else $error("standby entered");
  property p_go; o_in_break && i_dbg_go && !i_dbg_rst |=> !o_in_break;
  endproperty
  a_go: assert property (p_go) else $error("go ignored");
  property p_fl; $rose(o_cpu_rst) |=> o_irq_req == 3'h0; endproperty
  a_fl: assert property (p_fl) else $error("irq not flushed");
endmodule // drc_chk

// file: testbench/drc_emu.sv
// Debugger model: turns bench commands into one-cycle pulses.
// Assumes commands change just after a rising edge.
module drc_emu (
  input wire i_clk,
  input wire i_fire,
  input wire [1:0] i_op,
  input wire i_pin_hold,
  input wire i_in_break,
  output logic o_brk = 1'h0,
  output logic o_go = 1'h0,
  output logic o_step = 1'h0,
  output logic o_rst = 1'h0,
  output wire o_pin_rst_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // Target pin reset: released from time zero so the link can come up,
  // and gated off in break so a late request cannot upset the debugger
  assign o_pin_rst_n = !(i_pin_hold && !i_in_break);
  always @(posedge i_clk) begin
    o_brk <= i_fire && i_op == 2'h0;
    o_go <= i_fire && i_op == 2'h1;
    o_step <= i_fire && i_op == 2'h2;
    o_rst <= i_fire && i_op == 2'h3;
  end
endmodule // drc_emu

// file: testbench/drc_run_ctrl_test.sv
// Self-checking bench for drc_run_ctrl with a debugger model.
// Assumes core/drc_map.vh is on the include path.
module drc_run_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 1'h0;
  logic i_rst_n = 1'h0;
  logic fire = 1'h0;
  logic [1:0] op = 2'h0;
  logic [7:0] ev = 8'h00;
  logic pin_hold = 1'h0;
  wire brk, go, stp, drst, pin_n, ocr, oib, oh, ods, obr;
  wire [2:0] irq;
  wire [2:0] st = {oib, oh, ocr};
  wire [2:0] st2 = {ods, obr, oib};
  int n_errors = 0;
  int cmp_count = 0;
  drc_emu drc_emu_inst (.i_clk(i_clk), .i_fire(fire), .i_op(op),
    .i_pin_hold(pin_hold), .i_in_break(oib),
    .o_brk(brk), .o_go(go), .o_step(stp), .o_rst(drst), .o_pin_rst_n(pin_n));
  drc_run_ctrl drc_run_ctrl_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_pin_rst_n(pin_n), .i_sw_rst(ev[0]), .i_dbg_rst(drst),
    .i_dbg_break(brk), .i_dbg_step(stp), .i_dbg_go(go),
    .i_instr_done(ev[5]), .i_halt_instr(ev[6]),
    .i_deep_standby_instr(ev[7]), .i_maskable_user_interrupt(ev[1]),
    .i_fast_exception_interrupt(ev[2]), .i_float_exception_interrupt(ev[3]),
    .i_irq_ack(ev[4]), .o_cpu_rst(ocr), .o_in_break(oib), .o_halted(oh),
    .o_deep_standby_state(ods), .o_break_at_reset_vec(obr), .o_irq_req(irq));
  initial forever #25 i_clk = ~i_clk;
  task ck(input logic [2:0] g, input logic [2:0] e);
    cmp_count++;
    if (g !== e) begin
      $display("[ERR] %0t %h %h", $time, g, e);
      n_errors++;
    end
  endtask
  // Extra edge before sampling covers either answer latency
  task cmd(input logic [1:0] o);
    @(posedge i_clk) {fire, op} <= {1'h1, o};
    @(posedge i_clk) fire <= 1'h0;
    repeat (2) @(posedge i_clk);
    #1;
  endtask
  task tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task pulse(input logic [7:0] v);
    @(posedge i_clk) ev <= v;
    @(posedge i_clk) ev <= 8'h00;
    #1;
  endtask
  task summarize;
    if (n_errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task t_run;
    pulse(8'h04);
    ck(irq, 3'h2);
    pulse(8'h10);
  endtask
  // Pin reset while running: two sync stages, then the reset pulse
  task t_pin;
    @(posedge i_clk) pin_hold <= 1'h1;
    @(posedge i_clk) pin_hold <= 1'h0;
    tick(2);
    ck({2'h0, ocr}, 3'h1);
    tick(6);
    ck({2'h0, ocr}, 3'h0);
  endtask
  task t_brk;
    pulse(8'h60);
    ck(st, 3'h2);
    cmd(2'h0);
    ck(st, 3'h4);
  endtask
  task t_irq;
    pulse(8'h0E);
    ck(irq, 3'h0);
    cmd(2'h1);
    ck(irq, 3'h7);
    pulse(8'h10);
    tick(1);
    ck(irq, 3'h0);
    cmd(2'h0);
  endtask
  task t_step;
    cmd(2'h2);
    pulse(8'h0F);
    ck({2'h0, ocr}, 3'h0);
    pulse(8'h60);
    ck(st, 3'h4);
    cmd(2'h2);
    pulse(8'hA0);
    ck(st2, 3'h3);
    cmd(2'h2);
    cmd(2'h0);
    ck(st, 3'h4);
    cmd(2'h1);
    ck(st, 3'h1);
    ck(irq, 3'h0);
    tick(6);
    ck(st, 3'h0);
    ck(irq, 3'h0);
  endtask
  // Debugger reset from free run, then again from break
  task t_drst;
    cmd(2'h3);
    ck(st, 3'h5);
    tick(4);
    cmd(2'h3);
    ck(st, 3'h5);
    tick(8);
  endtask
  initial begin
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'h1;
    repeat (3) @(posedge i_clk);
    t_run;
    t_pin;
    t_brk;
    t_irq;
    t_step;
    t_drst;
    summarize;
  end
endmodule // drc_run_ctrl_test
bind drc_run_ctrl drc_chk drc_chk_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_dbg_rst(i_dbg_rst), .i_dbg_go(i_dbg_go), .o_cpu_rst(o_cpu_rst),
  .o_in_break(o_in_break), .o_halted(o_halted), .o_irq_req(o_irq_req),
  .o_deep_standby_state(o_deep_standby_state),
  .o_break_at_reset_vec(o_break_at_reset_vec));
